// ---- common/slpr_pkg.sv ----
package slpr_pkg;

   // system clock rate
   localparam int CLK_MHZ = 10;

   // opcodes
   localparam logic [7:0] OP_RDSR     = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD     = 8'h06;
   localparam logic [7:0] OP_CLEAR_STATUS_CMD     = 8'h30;
   localparam logic [7:0] OP_LOCK_CLR = 8'ha6;
   localparam logic [7:0] OP_LOCK_RD  = 8'ha7;
   localparam logic [7:0] OP_PWD_RD   = 8'he7;
   localparam logic [7:0] OP_PWD_PGM  = 8'he8;
   localparam logic [7:0] OP_PWD_UNL  = 8'he9;
   localparam logic [7:0] OP_SW_RST   = 8'hf0;

   // frame lengths and counter ceiling in serial clocks
   localparam logic [6:0] CMD_BITS   = 7'h08;
   localparam logic [6:0] PWD_FRAME  = 7'h48;
   localparam logic [6:0] CNT_SAT    = 7'h7f;

   // status byte positions
   localparam int SR_PERR = 6;
   localparam int SR_WEL  = 1;
   localparam int SR_WIP  = 0;

   // values after reset
   localparam logic [63:0] PWD_RST   = 64'hffff_ffff_ffff_ffff;
   localparam logic [2:0]  BP_RST    = 3'h0;

   // times as printed and derived cycle counts
   localparam int TPP_TYP_US  = 340;
   localparam int TPP_MAX_US  = 750;
   localparam int PROGRAM_SUSPEND_LATENCY_US     = 40;
   localparam int ERASE_SUSPEND_LATENCY_US     = 45;
   localparam int RESET_RECOVERY_TIME_NS     = 1000;
   localparam int TPP_TYP_CYC = TPP_TYP_US * CLK_MHZ;
   localparam int TPP_MAX_CYC = TPP_MAX_US * CLK_MHZ;
   localparam int PSL_CYC     = PROGRAM_SUSPEND_LATENCY_US * CLK_MHZ;
   localparam int ESL_CYC     = ERASE_SUSPEND_LATENCY_US * CLK_MHZ;
   localparam int RPH_CYC     = (RESET_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int SUSP_CYC    = 4;

   typedef logic [12:0] slpr_tmr_t;

   typedef enum logic [4:0] {
      F_IDLE = 5'h01,
      F_CMD  = 5'h02,
      F_DATA = 5'h04,
      F_OUT  = 5'h08,
      F_DROP = 5'h10
   } slpr_front_e;

   typedef enum logic [6:0] {
      C_STBY  = 7'h01,
      C_BUSY  = 7'h02,
      C_FAIL  = 7'h04,
      C_RECOV = 7'h08,
      C_CONT  = 7'h10,
      C_EMB   = 7'h20,
      C_SUSP  = 7'h40
   } slpr_core_e;

   typedef struct packed {
      logic pwd_mode_sel;
      logic bp_volatile;
   } slpr_cfg_s;

   typedef struct packed {
      logic write_in_progress;
      logic write_enable_latch;
      logic perr;
      logic lock;
   } slpr_stat_s;

endpackage

// ---- logic/slpr_cmd.sv ----
`timescale 1ns/1ns
module slpr_cmd #(
   parameter int unsigned PP_CYC = slpr_pkg::TPP_MAX_CYC
) (
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   input  wire logic               cs_n_i,
   input  wire logic               sck_i,
   input  wire logic               io0_i,
   input  wire logic               io4_i,
   input  wire slpr_pkg::slpr_cfg_s cfg_i,
   input  wire logic               freeze_set_i,
   input  wire logic               bp_wr_i,
   input  wire logic [2:0]         bp_i,
   input  wire logic               emb_start_i,
   input  wire logic               emb_erase_i,
   input  wire logic               suspend_i,
   input  wire logic               resume_i,
   input  wire logic               cont_enter_i,
   input  wire logic               pgm_fail_i,
   output logic                    so_o,
   output logic                    so_oe_o,
   output slpr_pkg::slpr_stat_s    stat_o,
   output logic [2:0]              bp_o,
   output logic                    freeze_o
);
   import slpr_pkg::*;

   localparam int PSL_LIM = PSL_CYC;
   localparam int ESL_LIM = ESL_CYC;

   logic        sck_q;
   logic        cs_n_q;
   slpr_front_e front_q;
   slpr_core_e  core_q;
   slpr_core_e  core_d;
   slpr_tmr_t   tmr_q;
   slpr_tmr_t   tmr_d;
   slpr_tmr_t   rem_q;
   logic [6:0]  cnt_q;
   logic [6:0]  op_sh_q;
   logic [7:0]  cmd_q;
   logic [7:0]  op_q;
   logic [63:0] data_q;
   logic [63:0] pwd_q;
   logic [5:0]  oc_q;
   logic        mbr_ok_q;
   logic        susp_pend_q;
   logic        emb_erase_q;
   logic        wel_q;
   logic        wip_q;
   logic        perr_q;
   logic        lock_q;
   logic        freeze_q;
   logic [2:0]  bp_q;
   logic        so_q;
   logic        oe_q;

   logic        sck_rise;
   logic        sck_fall;
   logic        cs_rise;
   logic        cs_fall;
   logic        stby;
   logic        last_cmd_bit;
   logic [7:0]  opc;
   logic        end8;
   logic        end72;
   logic        sw_rst;
   logic        clear_status_cmd;
   logic        write_enable_cmd;
   logic        go_clr;
   logic        go_pgm;
   logic        go_unl;
   logic        mode_bit_reset_cmd;
   logic        op_done;
   logic        pwd_match;
   logic        op_fail;
   logic [6:0]  dk;
   logic [5:0]  didx;
   logic [7:0]  sr_byte;
   logic        out_bit;

   // pins are synchronous, edges found against last sample
   assign sck_rise  = sck_i & ~sck_q;
   assign sck_fall  = ~sck_i & sck_q;
   assign cs_rise   = cs_n_i & ~cs_n_q;
   assign cs_fall   = ~cs_n_i & cs_n_q;
   assign stby      = (core_q == C_STBY);
   assign opc       = {op_sh_q, io0_i};
   assign last_cmd_bit = (front_q == F_CMD) && sck_rise && ~cs_n_i
                         && (cnt_q == CMD_BITS - 7'h01);
   assign end8      = cs_rise && (cnt_q == CMD_BITS);
   assign end72     = cs_rise && (cnt_q == PWD_FRAME);
   // reset acts on chip select rise
   assign sw_rst    = end8 && (cmd_q == OP_SW_RST) && (core_q != C_RECOV)
                      && (core_q != C_CONT) && (core_q != C_SUSP);
   assign clear_status_cmd      = end8 && (cmd_q == OP_CLEAR_STATUS_CMD)
                      && (stby || core_q == C_FAIL);
   assign write_enable_cmd      = end8 && (cmd_q == OP_WRITE_ENABLE_CMD) && stby;
   assign go_clr    = end8 && (cmd_q == OP_LOCK_CLR) && stby && wel_q;
   // enabled, in password mode, 64 bits
   assign go_pgm    = end72 && (cmd_q == OP_PWD_PGM) && stby && wel_q
                      && cfg_i.pwd_mode_sel;
   // unlock starts after full 64 bits
   assign go_unl    = end72 && (cmd_q == OP_PWD_UNL) && stby;
   assign mode_bit_reset_cmd       = cs_rise && (core_q == C_CONT) && (cnt_q == CMD_BITS)
                      && mbr_ok_q;
   assign op_done   = (core_q == C_BUSY) && (tmr_q == '0);
   assign pwd_match = (data_q == pwd_q);
   assign op_fail   = ((op_q == OP_PWD_UNL) && !pwd_match)
                      || ((op_q == OP_PWD_PGM) && pgm_fail_i);
   assign dk        = cnt_q - CMD_BITS;
   assign didx      = {dk[5:3], ~dk[2:0]};

   // busy device answers only status and recovery frames
   function automatic slpr_front_e cmd_front(input logic [7:0] op,
                                             input slpr_core_e core,
                                             input logic write_enable_latch,
                                             input logic pwd_sel);
      logic idle;
      idle = (core == C_STBY);
      cmd_front = F_DROP;
      if (core != C_CONT) begin
         case (op)
            OP_RDSR:    cmd_front = F_OUT;
            OP_LOCK_RD: cmd_front = idle ? F_OUT : F_DROP;
            OP_PWD_RD:  cmd_front = (idle && pwd_sel) ? F_OUT : F_DROP;
            OP_PWD_PGM: cmd_front = (idle && write_enable_latch && pwd_sel) ? F_DATA
                                                             : F_DROP;
            OP_PWD_UNL: cmd_front = idle ? F_DATA : F_DROP;
            default:    cmd_front = F_DROP;
         endcase
      end
   endfunction

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sck_q  <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q  <= sck_i;
         cs_n_q <= cs_n_i;
      end
   end

   // frame sequencing
   always_ff @(posedge clk_i) begin
      if (!nrst_i || cs_n_i) begin
         front_q <= F_IDLE;
      end else if (cs_fall) begin
         front_q <= F_CMD;
      end else if (last_cmd_bit) begin
         front_q <= cmd_front(opc, core_q, wel_q, cfg_i.pwd_mode_sel);
      end
   end

   // serial input shifting
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_q    <= '0;
         op_sh_q  <= '0;
         cmd_q    <= '0;
         mbr_ok_q <= 1'b0;
         data_q   <= '0;
      end else if (cs_fall) begin
         cnt_q    <= '0;
         mbr_ok_q <= 1'b1;
      end else if (sck_rise && ~cs_n_i) begin
         if (cnt_q != CNT_SAT) begin
            cnt_q <= cnt_q + 7'h01;
         end
         op_sh_q  <= opc[6:0];
         mbr_ok_q <= mbr_ok_q & io0_i & io4_i;
         if (last_cmd_bit) begin
            cmd_q <= opc;
         end
         // low byte first, msb first within byte
         if (front_q == F_DATA && cnt_q < PWD_FRAME) begin
            data_q[didx] <= io0_i;
         end
      end
   end

   always_comb begin
      sr_byte = 8'h00;
      sr_byte[SR_PERR] = perr_q;
      sr_byte[SR_WEL]  = wel_q;
      sr_byte[SR_WIP]  = wip_q;
      case (cmd_q)
         OP_PWD_RD:  out_bit = pwd_q[{oc_q[5:3], ~oc_q[2:0]}];
         // same byte each group of eight
         OP_LOCK_RD: out_bit = (oc_q[2:0] == 3'h7) ? lock_q : 1'b0;
         default:    out_bit = sr_byte[~oc_q[2:0]];
      endcase
   end

   // output driven only in read frames
   always_ff @(posedge clk_i) begin
      if (!nrst_i || cs_n_i) begin
         so_q <= 1'b0;
         oe_q <= 1'b0;
         oc_q <= '0;
      end else if (front_q == F_OUT && sck_fall) begin
         so_q <= out_bit;
         oe_q <= 1'b1;
         oc_q <= oc_q + 6'h01;
      end
   end

   always_comb begin
      core_d = core_q;
      tmr_d  = (tmr_q != '0) ? tmr_q - slpr_tmr_t'(1) : '0;
      case (core_q)
         C_STBY: begin
            if (sw_rst) begin
               core_d = C_RECOV;
               tmr_d  = slpr_tmr_t'(RPH_CYC - 1);
            end else if (cont_enter_i) begin
               core_d = C_CONT;
            end else if (go_clr || go_pgm || go_unl) begin
               // timed ops well under the page bound
               core_d = C_BUSY;
               tmr_d  = slpr_tmr_t'(TPP_TYP_CYC - 1);
            end else if (emb_start_i) begin
               core_d = C_EMB;
               tmr_d  = slpr_tmr_t'(PP_CYC - 1);
            end else if (resume_i && susp_pend_q) begin
               core_d = C_EMB;
               tmr_d  = rem_q;
            end
         end
         C_BUSY: begin
            if (sw_rst) begin
               core_d = C_RECOV;
               tmr_d  = slpr_tmr_t'(RPH_CYC - 1);
            end else if (op_done) begin
               core_d = op_fail ? C_FAIL : C_STBY;
            end
         end
         C_FAIL: begin
            if (sw_rst) begin
               core_d = C_RECOV;
               tmr_d  = slpr_tmr_t'(RPH_CYC - 1);
            end else if (clear_status_cmd) begin
               core_d = C_STBY;
            end
         end
         C_RECOV: begin
            if (tmr_q == '0) begin
               core_d = C_STBY;
            end
         end
         C_CONT: begin
            if (mode_bit_reset_cmd) begin
               core_d = C_STBY;
            end
         end
         C_EMB: begin
            if (sw_rst) begin
               core_d = C_RECOV;
               tmr_d  = slpr_tmr_t'(RPH_CYC - 1);
            end else if (suspend_i) begin
               core_d = C_SUSP;
               tmr_d  = slpr_tmr_t'(SUSP_CYC - 1);
            end else if (tmr_q == '0) begin
               core_d = C_STBY;
            end
         end
         C_SUSP: begin
            if (tmr_q == '0) begin
               core_d = C_STBY;
            end
         end
         default: core_d = C_STBY;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         core_q <= C_STBY;
         tmr_q  <= '0;
         wip_q  <= 1'b0;
      end else begin
         core_q <= core_d;
         tmr_q  <= tmr_d;
         // busy flag over busy, embedded, suspend and failed states
         wip_q  <= (core_d == C_BUSY) || (core_d == C_FAIL)
                   || (core_d == C_EMB) || (core_d == C_SUSP);
      end
   end

   // operation bookkeeping and suspend remainder
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         op_q        <= '0;
         rem_q       <= '0;
         susp_pend_q <= 1'b0;
         emb_erase_q <= 1'b0;
      end else begin
         if (go_clr || go_pgm || go_unl) begin
            op_q <= cmd_q;
         end
         if (stby && emb_start_i && !sw_rst && !cont_enter_i) begin
            emb_erase_q <= emb_erase_i;
         end
         if (sw_rst || (stby && resume_i)) begin
            susp_pend_q <= 1'b0;
         end else if (core_q == C_EMB && suspend_i) begin
            rem_q       <= tmr_q;
            susp_pend_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wel_q <= 1'b0;
      end else if (sw_rst) begin
         wel_q <= 1'b0;
      end else if (write_enable_cmd) begin
         wel_q <= 1'b1;
      end else if (op_done && op_q != OP_PWD_UNL) begin
         wel_q <= 1'b0;
      end
   end

   // clear first so a coincident failure still sets the flag
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         perr_q <= 1'b0;
      end else begin
         if (sw_rst || clear_status_cmd) begin
            perr_q <= 1'b0;
         end
         if (op_done && op_fail) begin
            perr_q <= 1'b1;
         end
      end
   end

   // power-up lock follows the protection mode
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         lock_q <= cfg_i.pwd_mode_sel;
      end else if (op_done && op_q == OP_LOCK_CLR) begin
         lock_q <= 1'b0;
      end else if (op_done && op_q == OP_PWD_UNL && pwd_match) begin
         lock_q <= 1'b1;
      end
   end

   // password reloads PWD_RST on hardware reset only, untouched by software reset
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pwd_q <= PWD_RST;
      end else if (op_done && op_q == OP_PWD_PGM && !pgm_fail_i) begin
         pwd_q <= data_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         freeze_q <= 1'b0;
      end else if (freeze_set_i) begin
         freeze_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         bp_q <= BP_RST;
      end else if (sw_rst && cfg_i.bp_volatile && !freeze_q) begin
         bp_q <= BP_RST;
      end else if (bp_wr_i && !freeze_q) begin
         bp_q <= bp_i;
      end
   end

   assign so_o     = so_q;
   assign so_oe_o  = oe_q;
   assign stat_o   = '{write_in_progress: wip_q, write_enable_latch: wel_q, perr: perr_q, lock: lock_q};
   assign bp_o     = bp_q;
   assign freeze_o = freeze_q;

   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   AST_LOCK_READ: assert property (
      front_q == F_OUT && sck_fall && ~cs_n_i && cmd_q == OP_LOCK_RD
      |=> so_oe_o && so_o == (($past(oc_q[2:0]) == 3'h7) && lock_q))
      else $error("lock byte bit wrong");
   AST_LOCK_CLEAR: assert property (
      op_done && op_q == OP_LOCK_CLR |=> !lock_q && !wel_q && !wip_q)
      else $error("lock clear did not complete");
   AST_CLEAR_FRAME: assert property (
      cs_rise && cmd_q == OP_LOCK_CLR && cnt_q != CMD_BITS && stby
      && !cont_enter_i && !emb_start_i && !resume_i |=> stby)
      else $error("lock clear ran on a bad frame");
   AST_PWD_HIDE: assert property (
      last_cmd_bit && opc == OP_PWD_RD && !cfg_i.pwd_mode_sel
      |=> front_q == F_DROP ##1 !so_oe_o)
      else $error("password read not ignored");
   AST_PGM_BUSY: assert property (
      go_pgm |=> wip_q [*8])
      else $error("program not busy");
   AST_UNLOCK_FAIL: assert property (
      op_done && op_q == OP_PWD_UNL && !pwd_match && !sw_rst
      |=> perr_q && wip_q && core_q == C_FAIL)
      else $error("failed unlock not flagged");
   AST_FAIL_STUCK: assert property (
      core_q == C_FAIL && !cs_rise |=> core_q == C_FAIL && wip_q)
      else $error("failure left without recovery");
   AST_UNLOCK_OK: assert property (
      op_done && op_q == OP_PWD_UNL && pwd_match |=> lock_q && !perr_q)
      else $error("matching unlock did not set lock");
   AST_SWRST_KEEP: assert property (
      sw_rst |=> lock_q == $past(lock_q) && freeze_q == $past(freeze_q)
      && core_q == C_RECOV && !wel_q && !perr_q)
      else $error("software reset lost kept bits");
   AST_SWRST_RECOV: assert property (
      sw_rst |=> (core_q == C_RECOV) [*8])
      else $error("software reset recovery cut short");
   AST_MBR_EXIT: assert property (
      mode_bit_reset_cmd |=> stby)
      else $error("mode reset did not leave continuous");
   AST_PSL: assert property (
      core_q == C_EMB && suspend_i && !emb_erase_q && !sw_rst
      |-> ##[1:PSL_LIM] !wip_q)
      else $error("program suspend too slow");
   AST_ESL: assert property (
      core_q == C_EMB && suspend_i && emb_erase_q && !sw_rst
      |-> ##[1:ESL_LIM] !wip_q)
      else $error("erase suspend too slow");
   AST_BUSY_SILENT: assert property (
      last_cmd_bit && !stby && opc != OP_RDSR |=> front_q != F_OUT)
      else $error("busy device answered a command");

endmodule

// ---- verif/slpr_host.sv ----
`timescale 1ns/1ns
module slpr_host (
   input  wire logic clk_i,
   input  wire logic so_i,
   input  wire logic so_oe_i,
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      io0_o,
   output logic      io4_o
);
   logic oe_seen;

   // sck parks low between frames, io0 flips once as chip select rises, then holds
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      io0_o = 1'b0;
      io4_o = 1'b1;
      oe_seen = 1'b0;
   end

   function automatic logic wire_bit(input logic [63:0] v, input int k);
      return v[8*(k/8)+7-k%8];
   endfunction

   task automatic frame(input logic [7:0] op, input logic [63:0] d,
                        input int nd, input int nr,
                        output logic [63:0] rd);
      rd = '0;
      oe_seen = 1'b0;
      @(negedge clk_i) cs_n_o = 1'b0;
      for (int k = 0; k < 8 + nd + nr; k++) begin
         @(negedge clk_i);
         sck_o = 1'b0;
         if (k < 8)
            io0_o = op[7-k];
         else if (k < 8 + nd)
            io0_o = wire_bit(d, k - 8);
         else
            io0_o = ~io0_o;
         io4_o = (op == 8'hff) ? 1'b1 : ~io0_o;
         repeat (2) @(negedge clk_i);
         // data settled one clk after the sampled fall
         if (k >= 8 + nd)
            rd = {rd[62:0], so_i};
         oe_seen = oe_seen | so_oe_i;
         sck_o = 1'b1;
         @(negedge clk_i);
      end
      @(negedge clk_i) sck_o = 1'b0;
      @(negedge clk_i) cs_n_o = 1'b1;
      io0_o = ~io0_o;
      repeat (2) @(negedge clk_i);
   endtask
endmodule

// ---- verif/slpr_cmd_tb_top.sv ----
`timescale 1ns/1ns
module slpr_cmd_tb_top;
   import slpr_pkg::*;
   localparam int PP = 50;
   logic        clk_i, nrst_i, cs_n, sck, io0, io4, so, so_oe, freeze;
   logic        frz_set, bp_wr, emb_start, emb_erase, susp, resm;
   logic        cont, pfail;
   logic [2:0]  bp_in, bp_q;
   slpr_cfg_s   cfg;
   slpr_stat_s  stat;
   logic [63:0] rd, pw, pw2;
   int          n_fail, checks;

   slpr_cmd #(.PP_CYC(PP)) DUT (
      .clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sck_i(sck),
      .io0_i(io0), .io4_i(io4), .cfg_i(cfg), .freeze_set_i(frz_set),
      .bp_wr_i(bp_wr), .bp_i(bp_in), .emb_start_i(emb_start),
      .emb_erase_i(emb_erase), .suspend_i(susp), .resume_i(resm),
      .cont_enter_i(cont), .pgm_fail_i(pfail), .so_o(so),
      .so_oe_o(so_oe), .stat_o(stat), .bp_o(bp_q), .freeze_o(freeze));

   slpr_host host (
      .clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
      .sck_o(sck), .io0_o(io0), .io4_o(io4));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // tail of a 72-bit password read: bytes 1..7, then byte 0 again
   function automatic logic [63:0] pwd_tail(input logic [63:0] p);
      for (int b = 0; b < 8; b++)
         pwd_tail[63-8*b -: 8] = p[8*((b+1)%8) +: 8];
   endfunction

   task automatic test_done();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmd(input logic [7:0] op);
      host.frame(op, 64'h0, 0, 0, rd);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_i) s = 1'b0;
   endtask

   // bounded wait, caller checks the flag afterwards
   task automatic wait_wip(input int lim);
      for (int c = 0; c < lim && stat.write_in_progress !== 1'b0; c++)
         @(negedge clk_i);
   endtask

   initial begin
      repeat (90000) @(posedge clk_i);
      n_fail++;
      test_done();
   end

   initial begin
      {nrst_i, frz_set, bp_wr, emb_start, emb_erase} = '0;
      {susp, resm, cont, pfail, bp_in} = '0;
      cfg = '{pwd_mode_sel: 1'b1, bp_volatile: 1'b1};
      n_fail = 0;
      checks = 0;
      void'($urandom(32'he6688779));
      repeat (3) @(negedge clk_i);
      nrst_i = 1'b1;
      @(negedge clk_i);
      chk({stat, bp_q, freeze}, 8'h10);
      host.frame(OP_LOCK_RD, 64'h0, 0, 16, rd);
      chk(rd[15:0], 16'h0101);
      cmd(OP_LOCK_CLR);
      chk(stat, 4'h1);
      cmd(OP_WRITE_ENABLE_CMD);
      host.frame(OP_LOCK_CLR, 64'h1, 1, 0, rd);
      chk(stat, 4'h5);
      cmd(OP_LOCK_CLR);
      chk(stat.write_in_progress, 1'b1);
      host.frame(OP_LOCK_RD, 64'h0, 0, 8, rd);
      chk(host.oe_seen, 1'b0);
      host.frame(OP_RDSR, 64'h0, 0, 8, rd);
      chk(rd[7:0], 8'h03);
      wait_wip(4000);
      chk(stat, 4'h0);
      pw = {$urandom, $urandom};
      host.frame(OP_PWD_PGM, pw, 64, 0, rd);
      chk(stat.write_in_progress, 1'b0);
      cmd(OP_WRITE_ENABLE_CMD);
      host.frame(OP_PWD_PGM, pw, 64, 0, rd);
      chk(stat.write_in_progress, 1'b1);
      wait_wip(4000);
      chk(stat, 4'h0);
      host.frame(OP_PWD_RD, 64'h0, 0, 72, rd);
      chk(rd, pwd_tail(pw));
      host.frame(OP_PWD_UNL, ~pw, 64, 0, rd);
      repeat (3500) @(negedge clk_i);
      chk(stat, 4'ha);
      cmd(OP_CLEAR_STATUS_CMD);
      chk(stat, 4'h0);
      host.frame(OP_PWD_UNL, pw, 64, 0, rd);
      chk(stat.write_in_progress, 1'b1);
      wait_wip(4000);
      chk(stat, 4'h1);
      bp_in = 3'($urandom) | 3'h1;
      pulse(bp_wr);
      chk(bp_q, bp_in);
      host.frame(OP_PWD_UNL, ~pw, 64, 0, rd);
      repeat (3500) @(negedge clk_i);
      cmd(OP_SW_RST);
      chk({stat, bp_q}, 7'h08);
      repeat (20) @(negedge clk_i);
      pulse(bp_wr);
      pulse(frz_set);
      cmd(OP_SW_RST);
      repeat (20) @(negedge clk_i);
      chk({freeze, bp_q}, {1'b1, bp_in});
      pfail = 1'b1;
      pw2 = {$urandom, $urandom};
      cmd(OP_WRITE_ENABLE_CMD);
      host.frame(OP_PWD_PGM, pw2, 64, 0, rd);
      repeat (3500) @(negedge clk_i);
      chk(stat.perr, 1'b1);
      cmd(OP_CLEAR_STATUS_CMD);
      pfail = 1'b0;
      chk(stat.write_in_progress, 1'b0);
      cfg.pwd_mode_sel = 1'b0;
      host.frame(OP_PWD_RD, 64'h0, 0, 8, rd);
      chk(host.oe_seen, 1'b0);
      cmd(OP_WRITE_ENABLE_CMD);
      host.frame(OP_PWD_PGM, pw2, 64, 0, rd);
      chk(stat.write_in_progress, 1'b0);
      pulse(cont);
      host.frame(OP_LOCK_RD, 64'h0, 0, 8, rd);
      chk(host.oe_seen, 1'b0);
      cmd(8'hff);
      host.frame(OP_LOCK_RD, 64'h0, 0, 8, rd);
      chk(host.oe_seen, 1'b1);
      // two suspend passes, erase flag random per pass
      for (int e = 0; e < 2; e++) begin
         emb_erase = 1'(e) ^ 1'($urandom);
         pulse(emb_start);
         chk(stat.write_in_progress, 1'b1);
         pulse(susp);
         wait_wip(emb_erase ? ESL_CYC : PSL_CYC);
         chk(stat.write_in_progress, 1'b0);
         pulse(resm);
         chk(stat.write_in_progress, 1'b1);
         wait_wip(PP + 20);
         chk(stat.write_in_progress, 1'b0);
      end
      // hardware reset ends a failed unlock and drops freeze
      host.frame(OP_PWD_UNL, ~pw, 64, 0, rd);
      repeat (3500) @(negedge clk_i);
      nrst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      @(negedge clk_i);
      chk({stat, bp_q, freeze}, 8'h00);
      // nonvolatile protect bits survive software reset
      cfg.bp_volatile = 1'b0;
      pulse(bp_wr);
      cmd(OP_SW_RST);
      chk(bp_q, bp_in);
      test_done();
   end
endmodule
